// [dpc_pkg.sv]
// package: register layout, threshold codes and delay times for discharge protection config
package dpc_pkg;
  localparam logic [7:0] SETUP_ADDR = 8'h05;
  localparam logic [7:0] TSCALE_ADDR = 8'h06;
  localparam logic [7:0] SWITCH_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] TSCALE_RESET = 8'h00;
  localparam int OC_AUTO_DIS_BIT = 7;
  localparam int OC_THR_HI_BIT = 6;
  localparam int OC_THR_LO_BIT = 5;
  localparam int SC_AUTO_DIS_BIT = 4;
  localparam int SC_THR_HI_BIT = 3;
  localparam int SC_THR_LO_BIT = 2;
  localparam int OC_TMO_HI_BIT = 1;
  localparam int OC_TMO_LO_BIT = 0;
  localparam int TIME_DIVIDE_BIT = 2;
  localparam int SWITCH_BIT = 0;
  localparam int OC_FLAG_BIT = 0;
  localparam int SC_FLAG_BIT = 1;
  localparam int CLK_HZ = 20000000;
  // delays in microseconds, as printed
  localparam int DLY_US_0 = 160000;
  localparam int DLY_US_1 = 320000;
  localparam int DLY_US_2 = 640000;
  localparam int DLY_US_3 = 1280000;
  localparam int DLYDIV_US_0 = 2500;
  localparam int DLYDIV_US_1 = 5000;
  localparam int DLYDIV_US_2 = 8000;
  localparam int DLYDIV_US_3 = 16000;
  localparam int CNT_W = 25;
  // threshold values in millivolts for the analog comparators
  localparam logic [10:0] OC_MV_0 = 11'h064;
  localparam logic [10:0] OC_MV_1 = 11'h078;
  localparam logic [10:0] OC_MV_2 = 11'h08c;
  localparam logic [10:0] OC_MV_3 = 11'h0a0;
  localparam logic [10:0] SC_MV_0 = 11'h0c8;
  localparam logic [10:0] SC_MV_1 = 11'h15e;
  localparam logic [10:0] SC_MV_2 = 11'h28a;
  localparam logic [10:0] SC_MV_3 = 11'h4b0;
endpackage

// [dpc_cfg_if.sv]
// interface: time-out code and divide bit passed from register file to the fault timer, and the delay limit the timer returns
`timescale 1ns/1ns
interface dpc_cfg_if;
  logic [1:0] timeout_code;
  logic time_divide;
  logic [dpc_pkg::CNT_W-1:0] limit;
  modport regs (output timeout_code, output time_divide, input limit);
  modport timer (input timeout_code, input time_divide, output limit);
endinterface

// [dpc_persist_timer.sv]
// module: qualifying timer that a condition must hold through before it counts as a fault
`timescale 1ns/1ns
module dpc_persist_timer #(
  parameter int SCALE = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cond,
  dpc_cfg_if.timer cfg,
  output logic fault
);
  // ****************************************
  // delay selection
  // ****************************************
  localparam int CYC_PER_US = dpc_pkg::CLK_HZ / 1000000;
  logic [dpc_pkg::CNT_W-1:0] lim_full;
  logic [dpc_pkg::CNT_W-1:0] lim_div;
  logic [dpc_pkg::CNT_W-1:0] cnt_q;
  logic [dpc_pkg::CNT_W-1:0] cnt_d;
  logic reached;

  assign lim_full = (cfg.timeout_code == 2'h0) ? dpc_pkg::CNT_W'(dpc_pkg::DLY_US_0 * CYC_PER_US / SCALE) :
                    (cfg.timeout_code == 2'h1) ? dpc_pkg::CNT_W'(dpc_pkg::DLY_US_1 * CYC_PER_US / SCALE) :
                    (cfg.timeout_code == 2'h2) ? dpc_pkg::CNT_W'(dpc_pkg::DLY_US_2 * CYC_PER_US / SCALE) :
                    dpc_pkg::CNT_W'(dpc_pkg::DLY_US_3 * CYC_PER_US / SCALE);
  assign lim_div = (cfg.timeout_code == 2'h0) ? dpc_pkg::CNT_W'(dpc_pkg::DLYDIV_US_0 * CYC_PER_US / SCALE) :
                   (cfg.timeout_code == 2'h1) ? dpc_pkg::CNT_W'(dpc_pkg::DLYDIV_US_1 * CYC_PER_US / SCALE) :
                   (cfg.timeout_code == 2'h2) ? dpc_pkg::CNT_W'(dpc_pkg::DLYDIV_US_2 * CYC_PER_US / SCALE) :
                   dpc_pkg::CNT_W'(dpc_pkg::DLYDIV_US_3 * CYC_PER_US / SCALE);
  assign cfg.limit = cfg.time_divide ? lim_div : lim_full;

  // ****************************************
  // persistence counter
  // ****************************************
  // a drop of the condition restarts the count, so glitches never accumulate
  assign reached = (cnt_q >= cfg.limit - dpc_pkg::CNT_W'(1));
  assign cnt_d = !cond ? '0 : (reached ? cnt_q : cnt_q + dpc_pkg::CNT_W'(1));
  assign fault = cond && reached;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// [dpc_discharge_protection_config.sv]
// module: discharge protection setup register, fault flags and switch auto-off
`timescale 1ns/1ns
// ****************************************
// Functional notes
// - overcurrent auto-disable bit 7 low: overcurrent fault turns off the switch
// - overcurrent auto-disable bit high: switch left alone on overcurrent
// - overcurrent always sets its flag; flag enables temp-sense supply
// - bits 6:5 pick overcurrent threshold 0.10/0.12/0.14/0.16 V
// - short auto-disable bit 4 low: short fault turns off the switch
// - short auto-disable bit high: switch left alone on short
// - short always sets its flag; flag enables temp-sense supply
// - bits 3:2 pick short threshold 0.20/0.35/0.65/1.20 V
// - bits 1:0 pick delay 160/320/640/1280 ms, divide off
// - divide on: delays become 2.5/5/8/16 ms
// - switch control bit clears on enabled overcurrent or short fault
// - time-scale register bit 2 selects the divided delay
// ****************************************
module dpc_discharge_protection_config #(
  parameter int TIME_SCALE = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic overcurrent_pin,
  input wire logic short_pin,
  output logic [10:0] overcurrent_sense_threshold,
  output logic [10:0] short_sense_threshold,
  output logic discharge_switch_on,
  output logic discharge_overcurrent_flag,
  output logic short_circuit_flag,
  output logic temp_sense_supply_out
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic oc_s1_q;
  logic oc_s2_q;
  logic sc_s1_q;
  logic sc_s2_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_s1_q <= 1'b0;
      oc_s2_q <= 1'b0;
      sc_s1_q <= 1'b0;
      sc_s2_q <= 1'b0;
    end
    else
    begin
      oc_s1_q <= overcurrent_pin;
      oc_s2_q <= oc_s1_q;
      sc_s1_q <= short_pin;
      sc_s2_q <= sc_s1_q;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] setup_q;
  logic [7:0] tscale_q;
  logic sw_q;
  logic sw_d;
  logic ocf_q;
  logic ocf_d;
  logic scf_q;
  logic scf_d;
  logic wr_setup;
  logic wr_tscale;
  logic wr_switch;
  logic wr_status;
  logic oc_fault;
  logic sc_fault;
  logic oc_auto_dis;
  logic sc_auto_dis;
  logic kill_switch;
  logic [1:0] oc_code;
  logic [1:0] sc_code;
  logic [7:0] rd_d;

  assign wr_setup = wr_en && (wr_addr == dpc_pkg::SETUP_ADDR);
  assign wr_tscale = wr_en && (wr_addr == dpc_pkg::TSCALE_ADDR);
  assign wr_switch = wr_en && (wr_addr == dpc_pkg::SWITCH_ADDR);
  assign wr_status = wr_en && (wr_addr == dpc_pkg::STATUS_ADDR);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_q <= dpc_pkg::SETUP_RESET;
      tscale_q <= dpc_pkg::TSCALE_RESET;
    end
    else
    begin
      if (wr_setup)
        setup_q <= wr_data;
      if (wr_tscale)
        tscale_q <= wr_data;
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  dpc_cfg_if cfg ();
  assign oc_auto_dis = setup_q[dpc_pkg::OC_AUTO_DIS_BIT];
  assign sc_auto_dis = setup_q[dpc_pkg::SC_AUTO_DIS_BIT];
  assign oc_code = {setup_q[dpc_pkg::OC_THR_HI_BIT], setup_q[dpc_pkg::OC_THR_LO_BIT]};
  assign sc_code = {setup_q[dpc_pkg::SC_THR_HI_BIT], setup_q[dpc_pkg::SC_THR_LO_BIT]};
  assign cfg.timeout_code = {setup_q[dpc_pkg::OC_TMO_HI_BIT], setup_q[dpc_pkg::OC_TMO_LO_BIT]};
  assign cfg.time_divide = tscale_q[dpc_pkg::TIME_DIVIDE_BIT];

  logic [10:0] oc_thr_d;
  logic [10:0] sc_thr_d;
  assign oc_thr_d = (oc_code == 2'h0) ? dpc_pkg::OC_MV_0 :
                    (oc_code == 2'h1) ? dpc_pkg::OC_MV_1 :
                    (oc_code == 2'h2) ? dpc_pkg::OC_MV_2 : dpc_pkg::OC_MV_3;
  assign sc_thr_d = (sc_code == 2'h0) ? dpc_pkg::SC_MV_0 :
                    (sc_code == 2'h1) ? dpc_pkg::SC_MV_1 :
                    (sc_code == 2'h2) ? dpc_pkg::SC_MV_2 : dpc_pkg::SC_MV_3;

  // ****************************************
  // fault qualification
  // ****************************************
  dpc_persist_timer #(
    .SCALE(TIME_SCALE)
  ) u_oc_timer (
    .clk(clk),
    .rst_n(rst_n),
    .cond(oc_s2_q),
    .cfg(cfg.timer),
    .fault(oc_fault)
  );
  // short delay is handled by the analog side; a synchronised level counts at once
  assign sc_fault = sc_s2_q;

  // ****************************************
  // flags and switch control
  // ****************************************
  // a fault in the cycle of a software clear wins, so no event is lost
  assign ocf_d = oc_fault ? 1'b1 : ((wr_status && wr_data[dpc_pkg::OC_FLAG_BIT]) ? 1'b0 : ocf_q);
  assign scf_d = sc_fault ? 1'b1 : ((wr_status && wr_data[dpc_pkg::SC_FLAG_BIT]) ? 1'b0 : scf_q);
  assign kill_switch = (oc_fault && !oc_auto_dis) || (sc_fault && !sc_auto_dis);
  // an enabled fault overrides a simultaneous software turn-on
  assign sw_d = kill_switch ? 1'b0 : (wr_switch ? wr_data[dpc_pkg::SWITCH_BIT] : sw_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_q <= 1'b0;
      ocf_q <= 1'b0;
      scf_q <= 1'b0;
      overcurrent_sense_threshold <= dpc_pkg::OC_MV_0;
      short_sense_threshold <= dpc_pkg::SC_MV_0;
      rd_data <= 8'h00;
    end
    else
    begin
      sw_q <= sw_d;
      ocf_q <= ocf_d;
      scf_q <= scf_d;
      overcurrent_sense_threshold <= oc_thr_d;
      short_sense_threshold <= sc_thr_d;
      rd_data <= rd_d;
    end
  end

  assign discharge_switch_on = sw_q;
  assign discharge_overcurrent_flag = ocf_q;
  assign short_circuit_flag = scf_q;
  assign temp_sense_supply_out = ocf_q || scf_q;

  // ****************************************
  // read mux
  // ****************************************
  assign rd_d = (rd_addr == dpc_pkg::SETUP_ADDR) ? setup_q :
                (rd_addr == dpc_pkg::TSCALE_ADDR) ? tscale_q :
                (rd_addr == dpc_pkg::SWITCH_ADDR) ? {7'h00, sw_q} :
                (rd_addr == dpc_pkg::STATUS_ADDR) ? {6'h00, scf_q, ocf_q} : 8'h00;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_oc_kill;
    oc_fault && !oc_auto_dis;
  endsequence
  sequence s_switch_off;
    !discharge_switch_on;
  endsequence

  a_oc_switch_off: assert property (@(posedge clk) disable iff (!rst_n)
    s_oc_kill |=> s_switch_off) else $error("switch stayed on after enabled overcurrent");
  a_oc_no_kill: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_fault && oc_auto_dis && !sc_fault && !wr_switch) |=> (discharge_switch_on == $past(sw_q)))
    else $error("switch changed on suppressed overcurrent");
  a_oc_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    oc_fault |=> discharge_overcurrent_flag && temp_sense_supply_out) else $error("overcurrent flag not set");
  a_sc_switch_off: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_fault && !sc_auto_dis) |=> !discharge_switch_on) else $error("switch stayed on after enabled short");
  a_sc_no_kill: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_fault && sc_auto_dis && !oc_fault && !wr_switch) |=> $stable(discharge_switch_on))
    else $error("switch changed on suppressed short");
  a_sc_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    sc_fault |=> short_circuit_flag && temp_sense_supply_out) else $error("short flag not set");
  a_oc_thresh_map: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_code == 2'h2) |=> (overcurrent_sense_threshold == 11'h08c)) else $error("overcurrent threshold wrong");
  a_sc_thresh_map: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_code == 2'h3) |=> (short_sense_threshold == 11'h4b0)) else $error("short threshold wrong");
  a_div_limit: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.time_divide && cfg.timeout_code == 2'h0) |-> (cfg.limit == 25'(50000 / TIME_SCALE)))
    else $error("divided delay wrong");
  a_full_limit: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.time_divide && cfg.timeout_code == 2'h1) |-> (cfg.limit == 25'(6400000 / TIME_SCALE)))
    else $error("full delay wrong");
  a_oc_persist: assert property (@(posedge clk) disable iff (!rst_n)
    (!oc_s2_q ##1 oc_s2_q) |-> !oc_fault) else $error("overcurrent qualified without delay");

  // ****************************************
  // assertions: threshold and delay maps
  // ****************************************
  a_oc_thr_code0: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_code == 2'h0) |=> (overcurrent_sense_threshold == 11'h064)) else $error("overcurrent threshold wrong");
  a_oc_thr_code1: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_code == 2'h1) |=> (overcurrent_sense_threshold == 11'h078)) else $error("overcurrent threshold wrong");
  a_oc_thr_code3: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_code == 2'h3) |=> (overcurrent_sense_threshold == 11'h0a0)) else $error("overcurrent threshold wrong");
  a_sc_thr_code0: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_code == 2'h0) |=> (short_sense_threshold == 11'h0c8)) else $error("short threshold wrong");
  a_sc_thr_code1: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_code == 2'h1) |=> (short_sense_threshold == 11'h15e)) else $error("short threshold wrong");
  a_sc_thr_code2: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_code == 2'h2) |=> (short_sense_threshold == 11'h28a)) else $error("short threshold wrong");
  // expected counts are delay times 20 cycles per microsecond, shortened by the same scale as the timer
  a_full_code0: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.time_divide && cfg.timeout_code == 2'h0) |-> (cfg.limit == 25'(3200000 / TIME_SCALE)))
    else $error("full delay wrong");
  a_full_code2: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.time_divide && cfg.timeout_code == 2'h2) |-> (cfg.limit == 25'(12800000 / TIME_SCALE)))
    else $error("full delay wrong");
  a_full_code3: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.time_divide && cfg.timeout_code == 2'h3) |-> (cfg.limit == 25'(25600000 / TIME_SCALE)))
    else $error("full delay wrong");
  a_div_code1: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.time_divide && cfg.timeout_code == 2'h1) |-> (cfg.limit == 25'(100000 / TIME_SCALE)))
    else $error("divided delay wrong");
  a_div_code2: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.time_divide && cfg.timeout_code == 2'h2) |-> (cfg.limit == 25'(160000 / TIME_SCALE)))
    else $error("divided delay wrong");
  a_div_code3: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.time_divide && cfg.timeout_code == 2'h3) |-> (cfg.limit == 25'(320000 / TIME_SCALE)))
    else $error("divided delay wrong");

  // ****************************************
  // assertions: flags, switch and registers
  // ****************************************
  // set wins over a clear in the same cycle, so a fault is never lost
  a_oc_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (oc_fault && wr_status && wr_data[dpc_pkg::OC_FLAG_BIT]) |=> discharge_overcurrent_flag)
    else $error("overcurrent flag lost to clear");
  a_sc_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (sc_fault && wr_status && wr_data[dpc_pkg::SC_FLAG_BIT]) |=> short_circuit_flag)
    else $error("short flag lost to clear");
  a_oc_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (discharge_overcurrent_flag && !(wr_status && wr_data[dpc_pkg::OC_FLAG_BIT])) |=> discharge_overcurrent_flag)
    else $error("overcurrent flag dropped");
  a_sc_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (short_circuit_flag && !(wr_status && wr_data[dpc_pkg::SC_FLAG_BIT])) |=> short_circuit_flag)
    else $error("short flag dropped");
  a_oc_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_status && wr_data[dpc_pkg::OC_FLAG_BIT] && !oc_fault) |=> !discharge_overcurrent_flag)
    else $error("overcurrent flag not cleared");
  a_sc_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_status && wr_data[dpc_pkg::SC_FLAG_BIT] && !sc_fault) |=> !short_circuit_flag)
    else $error("short flag not cleared");
  a_switch_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_switch && !kill_switch) |=> (discharge_switch_on == $past(wr_data[dpc_pkg::SWITCH_BIT])))
    else $error("switch write lost");
  a_switch_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!wr_switch && !kill_switch) |=> $stable(discharge_switch_on))
    else $error("switch changed without cause");
  a_switch_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_addr == dpc_pkg::SWITCH_ADDR) |=> (rd_data == {7'h00, $past(sw_q)})) else $error("switch readback wrong");
  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_addr == dpc_pkg::STATUS_ADDR) |=> (rd_data == {6'h00, $past(scf_q), $past(ocf_q)}))
    else $error("status readback wrong");
  a_timeout_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_setup |=> (cfg.timeout_code == $past(wr_data[dpc_pkg::OC_TMO_HI_BIT:dpc_pkg::OC_TMO_LO_BIT])))
    else $error("time-out field not written");
  a_oc_dis_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_setup |=> (oc_auto_dis == $past(wr_data[dpc_pkg::OC_AUTO_DIS_BIT])))
    else $error("overcurrent auto-disable not written");
  a_sc_dis_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_setup |=> (sc_auto_dis == $past(wr_data[dpc_pkg::SC_AUTO_DIS_BIT])))
    else $error("short auto-disable not written");
  a_divide_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_tscale |=> (cfg.time_divide == $past(wr_data[dpc_pkg::TIME_DIVIDE_BIT])))
    else $error("divide bit not written");

  // a short run must never qualify; only meaningful while every limit exceeds eight cycles
  sequence s_oc_fresh;
    !oc_s2_q ##1 oc_s2_q [*8];
  endsequence
  sequence s_oc_drop;
    oc_s2_q ##1 !oc_s2_q;
  endsequence
  a_oc_short_run: assert property (@(posedge clk) disable iff (!rst_n)
    s_oc_fresh |-> !oc_fault) else $error("overcurrent qualified early");
  a_oc_drop_reset: assert property (@(posedge clk) disable iff (!rst_n)
    s_oc_drop |=> !oc_fault) else $error("overcurrent count not restarted");
endmodule

// [dpc_host_model.sv]
// host model: the controller that writes and reads the setup registers
`timescale 1ns/1ns
module dpc_host_model (
  input wire logic clk,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial
  begin
    wr_en = 1'b0;
    wr_addr = 8'hff;
    wr_data = 8'h5a;
    rd_addr = 8'hff;
  end
  // one-cycle strobe; address and data turn to junk once released so nothing leans on stale values
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  // read data is registered, so it is taken one cycle after the address
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    d = rd_data;
  endtask
endmodule

// [testbench.sv]
// testbench: self-checking bench for the discharge protection setup block
`timescale 1ns/1ns
module testbench;
  // time scale shortens every delay by this factor
  localparam int TS = 1000;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic overcurrent_pin = 1'b0;
  logic short_pin = 1'b0;
  wire wr_en;
  wire [7:0] wr_addr, wr_data, rd_addr, rd_data;
  wire [10:0] oc_thr, sc_thr;
  wire sw_on, oc_flag, sc_flag, temp_out;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] rd;
  always #25 clk = ~clk;
  dpc_host_model u_dpc_host_model (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data));
  dpc_discharge_protection_config #(.TIME_SCALE(TS)) u_dpc_discharge_protection_config (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .overcurrent_pin(overcurrent_pin), .short_pin(short_pin),
    .overcurrent_sense_threshold(oc_thr), .short_sense_threshold(sc_thr), .discharge_switch_on(sw_on),
    .discharge_overcurrent_flag(oc_flag), .short_circuit_flag(sc_flag), .temp_sense_supply_out(temp_out));
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
      n_errors++;
    end
  endtask
  function automatic int lim(input int dv, input int c);
    int t[8];
    t = '{dpc_pkg::DLY_US_0, dpc_pkg::DLY_US_1, dpc_pkg::DLY_US_2, dpc_pkg::DLY_US_3,
      dpc_pkg::DLYDIV_US_0, dpc_pkg::DLYDIV_US_1, dpc_pkg::DLYDIV_US_2, dpc_pkg::DLYDIV_US_3};
    return t[dv * 4 + c] * (dpc_pkg::CLK_HZ / 1000000) / TS;
  endfunction
  // pins drop first and settle through the synchroniser, since a live fault would win over the clear
  task automatic clear_flags();
    overcurrent_pin = 1'b0;
    short_pin = 1'b0;
    repeat (5) @(negedge clk);
    u_dpc_host_model.write(dpc_pkg::STATUS_ADDR, 8'h03);
    chk("flags cleared", 11'h000, {oc_flag, sc_flag, temp_out});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("oc threshold", 11'h064, oc_thr);
    chk("sc threshold", 11'h0c8, sc_thr);
    chk("outputs", 11'h000, {sw_on, oc_flag, sc_flag, temp_out});
    u_dpc_host_model.read(dpc_pkg::SETUP_ADDR, rd);
    chk("setup reset", 11'h000, rd);
    $display("reset test done");
  endtask
  task automatic t_thresholds();
    logic [10:0] oc_mv[4] = '{11'h064, 11'h078, 11'h08c, 11'h0a0};
    logic [10:0] sc_mv[4] = '{11'h0c8, 11'h15e, 11'h28a, 11'h4b0};
    for (int i = 0; i < 4; i++)
    begin
      u_dpc_host_model.write(dpc_pkg::SETUP_ADDR, {1'b0, i[1:0], 1'b1, 2'(3 - i), i[1:0]});
      u_dpc_host_model.read(dpc_pkg::SETUP_ADDR, rd);
      chk("setup readback", {3'h0, 1'b0, i[1:0], 1'b1, 2'(3 - i), i[1:0]}, rd);
      chk("oc threshold", oc_mv[i], oc_thr);
      chk("sc threshold", sc_mv[3 - i], sc_thr);
    end
    u_dpc_host_model.write(8'h00, 8'h3f);
    u_dpc_host_model.read(8'h00, rd);
    chk("unmapped read", 11'h000, rd);
    u_dpc_host_model.read(dpc_pkg::SETUP_ADDR, rd);
    chk("setup untouched", 11'h073, rd);
    $display("threshold test done");
  endtask
  task automatic t_delay(input int dv, input int c);
    int n;
    n = lim(dv, c);
    u_dpc_host_model.write(dpc_pkg::TSCALE_ADDR, {5'h00, dv[0], 2'h0});
    u_dpc_host_model.write(dpc_pkg::SETUP_ADDR, {6'h20, c[1:0]});
    overcurrent_pin = 1'b1;
    repeat (n - 1) @(negedge clk);
    chk("flag before delay", 11'h000, oc_flag);
    repeat (6) @(negedge clk);
    chk("flag after delay", 11'h001, oc_flag);
    clear_flags();
    $display("delay test done: divide %0d code %0d", dv, c);
  endtask
  task automatic t_restart();
    u_dpc_host_model.write(dpc_pkg::TSCALE_ADDR, 8'h04);
    u_dpc_host_model.write(dpc_pkg::SETUP_ADDR, 8'h80);
    overcurrent_pin = 1'b1;
    repeat (lim(1, 0) - 10) @(negedge clk);
    overcurrent_pin = 1'b0;
    repeat (4) @(negedge clk);
    overcurrent_pin = 1'b1;
    repeat (lim(1, 0) - 10) @(negedge clk);
    chk("flag after broken run", 11'h000, oc_flag);
    repeat (16) @(negedge clk);
    chk("flag after full run", 11'h001, oc_flag);
    clear_flags();
    $display("restart test done");
  endtask
  task automatic t_auto(input bit sc, input bit dis);
    u_dpc_host_model.write(dpc_pkg::TSCALE_ADDR, 8'h04);
    u_dpc_host_model.write(dpc_pkg::SETUP_ADDR, sc ? {3'h0, dis, 4'h0} : {dis, 7'h00});
    u_dpc_host_model.write(dpc_pkg::SWITCH_ADDR, 8'h01);
    chk("switch on", 11'h001, sw_on);
    overcurrent_pin = !sc;
    short_pin = sc;
    repeat (lim(1, 0) + 6) @(negedge clk);
    chk("flags", {!sc, sc, 1'b1}, {oc_flag, sc_flag, temp_out});
    u_dpc_host_model.read(dpc_pkg::STATUS_ADDR, rd);
    chk("status bits", {9'h000, sc, !sc}, rd);
    chk("switch", dis, sw_on);
    u_dpc_host_model.read(dpc_pkg::SWITCH_ADDR, rd);
    chk("switch bit", dis, rd);
    clear_flags();
    $display("auto-off test done: short %0d disable %0d", sc, dis);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_thresholds();
    for (int c = 0; c < 4; c++)
      t_delay(1, c);
    t_delay(0, 0);
    t_delay(0, 1);
    t_restart();
    for (int i = 0; i < 4; i++)
      t_auto(i[1], i[0]);
    end_of_test();
  end
endmodule
